/* logic/tmr_dual_timer.v */
// Overview of operation
// - Compare matches raise channel interrupt, except PWM
// - Compare accepts any byte, writable while running
// - Reset clears both mode control registers
// - Enable bit: 0 clears and halts, 1 counts
// - Mode bit: clear-on-match or free-running PWM
// - Second channel bit 4 selects 16-bit cascade
// - Bits 3:2 write clear or set output flop
// - Flop set/clear bits always read back zero
// - Bit 1: toggle enable, or PWM polarity
// - Bit 0 enables timer output pin
// - PWM output inactive when count enable cleared
// - Reset clears both clock-select registers
// - Clock code picks external edge or divider
// - Interval match clears counter, period compare plus one
// - Compare write at match suppresses that match
// - Counters read-only, increment on count clock
// - Counter read pauses count clock briefly
// - Cascade: first enable clear zeroes both counters
// - Cascade: joint match interrupts both, clears both
`timescale 1ns/1ns
`include "tmr_map.vh"

module tmr_dual_timer (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [`TMR_ADDR_W-1:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    input wire event_input_a_i,
    input wire event_input_b_i,
    output wire wave_output_a_o,
    output wire wave_output_b_o,
    output wire output_enable_a_o,
    output wire output_enable_b_o,
    output wire match_irq_a_o,
    output wire match_irq_b_o
);

    // Per-channel views shared between the two channels
    wire [15:0] cnt_w;
    wire [15:0] cmp_w;
    wire [15:0] mode_w;
    wire [5:0] clksel_w;
    wire [1:0] eff_w;
    wire [1:0] wr_cmp_w;
    wire [1:0] wave_w;
    wire [1:0] irq_w;
    wire [1:0] event_w;
    wire cascade;
    wire casc_match;
    wire carry_a;
    wire rd_cnt_any;

    assign event_w = {event_input_b_i, event_input_a_i};

    // Address match, used by the write and counter-read decodes
    function hit;
        input [`TMR_ADDR_W-1:0] addr;
        input [`TMR_ADDR_W-1:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    assign cascade = mode_w[8 + `TMR_BIT_CASCADE];
    assign rd_cnt_any = rd_i && (hit(addr_i, `TMR_COUNTER_A_ADDR)
        || hit(addr_i, `TMR_COUNTER_B_ADDR));

    // Joint 16-bit match taken on the low channel's count clock
    assign casc_match = cascade && eff_w[0]
        && (cnt_w[7:0] == cmp_w[7:0]) && (cnt_w[15:8] == cmp_w[15:8])
        && !wr_cmp_w[0] && !wr_cmp_w[1];

    // Low byte rolls over into the high byte
    assign carry_a = cascade && eff_w[0] && (cnt_w[7:0] == `TMR_COUNT_MAX)
        && !casc_match;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : gen_ch
            localparam [`TMR_ADDR_W-1:0] MODE_ADDR =
                (i == 0) ? `TMR_MODE_A_ADDR : `TMR_MODE_B_ADDR;
            localparam [`TMR_ADDR_W-1:0] CLKSEL_ADDR =
                (i == 0) ? `TMR_CLKSEL_A_ADDR : `TMR_CLKSEL_B_ADDR;
            localparam [`TMR_ADDR_W-1:0] CMP_ADDR =
                (i == 0) ? `TMR_COMPARE_A_ADDR : `TMR_COMPARE_B_ADDR;
            localparam [`TMR_ADDR_W-1:0] CNT_ADDR =
                (i == 0) ? `TMR_COUNTER_A_ADDR : `TMR_COUNTER_B_ADDR;

            reg [7:0] mode_reg;
            reg [2:0] clksel_reg;
            reg [7:0] cmp_reg;
            reg [7:0] cnt_reg;
            reg [7:0] cnt_next;
            reg flop_reg;
            reg pwm_lvl_reg;
            reg pend_reg;
            reg irq_reg;
            reg wave_reg;
            wire gen_tick;
            wire run;
            wire pwm;
            wire inv_pol;
            wire tick_raw;
            wire pause;
            wire eff;
            wire match;
            wire ovf;
            wire clear_hit;
            wire wr_mode;
            wire wr_cmp;
            wire linked;

            // High channel in cascade follows the low channel's enable
            assign linked = cascade && (i == 1);
            assign run = linked ? mode_w[`TMR_BIT_COUNT_EN]
                : mode_reg[`TMR_BIT_COUNT_EN];
            assign pwm = mode_reg[`TMR_BIT_PWM_SEL] && !cascade;
            assign inv_pol = mode_reg[`TMR_BIT_INV_POL];
            assign wr_mode = wr_i && hit(addr_i, MODE_ADDR);
            assign wr_cmp = wr_i && hit(addr_i, CMP_ADDR);

            tmr_tick_gen u_tick (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .run_i(mode_reg[`TMR_BIT_COUNT_EN]),
                .code_i(clksel_reg),
                .event_i(event_w[i]),
                .tick_o(gen_tick)
            );

            // A counter read holds off the count clock for one cycle
            assign tick_raw = linked ? carry_a : gen_tick;
            assign pause = cascade ? rd_cnt_any
                : (rd_i && hit(addr_i, CNT_ADDR));
            assign eff = linked ? carry_a
                : ((tick_raw || pend_reg) && !pause && run);

            // Own match; a compare write in the same cycle masks it
            assign match = eff && (cnt_reg == cmp_reg) && !wr_cmp;
            assign ovf = eff && (cnt_reg == `TMR_COUNT_MAX);
            assign clear_hit = cascade ? casc_match : (match && !pwm);

            // Counter next value
            always @* begin
                cnt_next = cnt_reg;
                if (!run) begin
                    cnt_next = `TMR_COUNT_RESET;
                end else if (clear_hit) begin
                    cnt_next = `TMR_COUNT_RESET;
                end else if (eff) begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end

            // Control registers and count state
            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    mode_reg <= `TMR_MODE_RESET;
                    clksel_reg <= `TMR_CLKSEL_RESET;
                    cmp_reg <= `TMR_COMPARE_RESET;
                    cnt_reg <= `TMR_COUNT_RESET;
                    pend_reg <= 1'b0;
                end else begin
                    if (wr_mode) begin
                        // Flop action bits are not stored, so read as zero
                        mode_reg <= {wdata_i[7:6], 1'b0,
                            (i == 1) ? wdata_i[4] : 1'b0, 2'b00,
                            wdata_i[1:0]};
                    end
                    if (wr_i && hit(addr_i, CLKSEL_ADDR)) begin
                        clksel_reg <= wdata_i[`TMR_CS_MSB:`TMR_CS_LSB];
                    end
                    if (wr_cmp) begin
                        cmp_reg <= wdata_i;
                    end
                    cnt_reg <= cnt_next;
                    pend_reg <= (tick_raw || pend_reg) && pause && run && !linked;
                end
            end

            // Output flop: software action wins over a same-cycle toggle
            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    flop_reg <= 1'b0;
                end else if (wr_mode && wdata_i[`TMR_BIT_FLOP_CLEAR]
                        && !wdata_i[`TMR_BIT_FLOP_SET]) begin
                    flop_reg <= 1'b0;
                end else if (wr_mode && wdata_i[`TMR_BIT_FLOP_SET]
                        && !wdata_i[`TMR_BIT_FLOP_CLEAR]) begin
                    flop_reg <= 1'b1;
                end else if (clear_hit && !pwm && inv_pol) begin
                    flop_reg <= !flop_reg;
                end
            end

            // PWM level: active from overflow until compare match
            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    pwm_lvl_reg <= 1'b0;
                end else if (!run || !pwm) begin
                    pwm_lvl_reg <= 1'b0;
                end else if (match) begin
                    pwm_lvl_reg <= 1'b0;
                end else if (ovf) begin
                    pwm_lvl_reg <= 1'b1;
                end
            end

            // Interrupt pulse and registered pin level
            always @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    irq_reg <= 1'b0;
                    wave_reg <= 1'b0;
                end else begin
                    if (cascade) begin
                        irq_reg <= casc_match;
                    end else if (pwm) begin
                        irq_reg <= ovf;
                    end else begin
                        irq_reg <= match;
                    end
                    // Polarity bit inverts the PWM level for active low
                    wave_reg <= pwm ? (pwm_lvl_reg ^ inv_pol) : flop_reg;
                end
            end

            assign cnt_w[i*8 +: 8] = cnt_reg;
            assign cmp_w[i*8 +: 8] = cmp_reg;
            assign mode_w[i*8 +: 8] = mode_reg;
            assign clksel_w[i*3 +: 3] = clksel_reg;
            assign eff_w[i] = eff;
            assign wr_cmp_w[i] = wr_cmp;
            assign wave_w[i] = wave_reg;
            assign irq_w[i] = irq_reg;
        end
    endgenerate

    // Pin outputs; the port takes the pin back when output is off
    assign wave_output_a_o = wave_w[0];
    assign wave_output_b_o = wave_w[1];
    assign output_enable_a_o = mode_w[`TMR_BIT_OUT_EN];
    assign output_enable_b_o = mode_w[8 + `TMR_BIT_OUT_EN];
    assign match_irq_a_o = irq_w[0];
    assign match_irq_b_o = irq_w[1];

    // Read data registered one cycle after the read strobe
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `TMR_MODE_A_ADDR: rdata_o <= mode_w[7:0];
                `TMR_MODE_B_ADDR: rdata_o <= mode_w[15:8];
                `TMR_CLKSEL_A_ADDR: rdata_o <= {5'h00, clksel_w[2:0]};
                `TMR_CLKSEL_B_ADDR: rdata_o <= {5'h00, clksel_w[5:3]};
                `TMR_COMPARE_A_ADDR: rdata_o <= cmp_w[7:0];
                `TMR_COMPARE_B_ADDR: rdata_o <= cmp_w[15:8];
                `TMR_COUNTER_A_ADDR: rdata_o <= cnt_w[7:0];
                `TMR_COUNTER_B_ADDR: rdata_o <= cnt_w[15:8];
                default: rdata_o <= 8'h00;
            endcase
        end
    end

endmodule

/* common/tmr_map.vh */
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// Register addresses on the CPU data space
`define TMR_ADDR_W 20
`define TMR_CLKSEL_B_ADDR 20'hff57
`define TMR_MODE_A_ADDR 20'hff68
`define TMR_MODE_B_ADDR 20'hff69
`define TMR_COMPARE_A_ADDR 20'hff6a
`define TMR_COMPARE_B_ADDR 20'hff6b
`define TMR_CLKSEL_A_ADDR 20'hff6c
`define TMR_COUNTER_A_ADDR 20'hff70
`define TMR_COUNTER_B_ADDR 20'hff71

// Mode control field positions
`define TMR_BIT_COUNT_EN 7
`define TMR_BIT_PWM_SEL 6
`define TMR_BIT_CASCADE 4
`define TMR_BIT_FLOP_SET 3
`define TMR_BIT_FLOP_CLEAR 2
`define TMR_BIT_INV_POL 1
`define TMR_BIT_OUT_EN 0

// Clock-select code field
`define TMR_CS_MSB 2
`define TMR_CS_LSB 0

// Reset values
`define TMR_MODE_RESET 8'h00
`define TMR_CLKSEL_RESET 3'h0
`define TMR_COMPARE_RESET 8'h00
`define TMR_COUNT_RESET 8'h00
`define TMR_COUNT_MAX 8'hff

// Count clock codes
`define TMR_CS_EXT_FALL 3'h0
`define TMR_CS_EXT_RISE 3'h1
`define TMR_CS_DIV4 3'h2
`define TMR_CS_DIV8 3'h3
`define TMR_CS_DIV16 3'h4
`define TMR_CS_DIV32 3'h5
`define TMR_CS_DIV128 3'h6
`define TMR_CS_DIV512 3'h7

// Prescaler width and tap masks (ratio minus one)
`define TMR_DIV_W 9
`define TMR_DIV4_MASK 9'h003
`define TMR_DIV8_MASK 9'h007
`define TMR_DIV16_MASK 9'h00f
`define TMR_DIV32_MASK 9'h01f
`define TMR_DIV128_MASK 9'h07f
`define TMR_DIV512_MASK 9'h1ff

`endif

/* logic/tmr_tick_gen.v */
`timescale 1ns/1ns
`include "tmr_map.vh"

module tmr_tick_gen (
    input wire clk_i,
    input wire sys_rst_i,
    input wire run_i,
    input wire [2:0] code_i,
    input wire event_i,
    output reg tick_o
);

    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg level_reg;
    reg [`TMR_DIV_W-1:0] div_reg;
    reg [`TMR_DIV_W-1:0] mask;
    wire settle;
    wire rise;
    wire fall;

    // Tap mask for the selected internal division ratio
    always @* begin
        case (code_i)
            `TMR_CS_DIV4: mask = `TMR_DIV4_MASK;
            `TMR_CS_DIV8: mask = `TMR_DIV8_MASK;
            `TMR_CS_DIV16: mask = `TMR_DIV16_MASK;
            `TMR_CS_DIV32: mask = `TMR_DIV32_MASK;
            `TMR_CS_DIV128: mask = `TMR_DIV128_MASK;
            default: mask = `TMR_DIV512_MASK;
        endcase
    end

    // Accepted level change only once stages two and three agree
    assign settle = (sync2_reg == sync3_reg) && (sync3_reg != level_reg);
    assign rise = settle && sync3_reg;
    assign fall = settle && !sync3_reg;

    // Pin synchroniser runs always so no stale edge appears at start
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            sync1_reg <= event_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (settle) begin
                level_reg <= sync3_reg;
            end
        end
    end

    // Prescaler held at zero while counting is disabled
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_reg <= {`TMR_DIV_W{1'b0}};
            tick_o <= 1'b0;
        end else if (!run_i) begin
            div_reg <= {`TMR_DIV_W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            div_reg <= div_reg + {{(`TMR_DIV_W-1){1'b0}}, 1'b1};
            case (code_i)
                `TMR_CS_EXT_FALL: tick_o <= fall;
                `TMR_CS_EXT_RISE: tick_o <= rise;
                default: tick_o <= ((div_reg & mask) == mask);
            endcase
        end
    end

endmodule

/* dv/tmr_dual_timer_monitor.sv */
`timescale 1ns/1ns
`include "tmr_map.vh"
module tmr_dual_timer_monitor (
    input logic clk_i,
    input logic sys_rst_i,
    input logic [`TMR_ADDR_W-1:0] addr_i,
    input logic wr_i,
    input logic rd_i,
    input logic [7:0] wdata_i,
    input logic [7:0] rdata_o,
    input logic event_input_a_i,
    input logic event_input_b_i,
    input logic wave_output_a_o,
    input logic wave_output_b_o,
    input logic output_enable_a_o,
    input logic output_enable_b_o,
    input logic match_irq_a_o,
    input logic match_irq_b_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Decoded mode writes and reads, shared by several checks
    wire wma = wr_i && addr_i == `TMR_MODE_A_ADDR;
    wire wmb = wr_i && addr_i == `TMR_MODE_B_ADDR;
    wire rdm = rd_i && (addr_i == `TMR_MODE_A_ADDR || addr_i == `TMR_MODE_B_ADDR);
    chk_pin_enable_a: assert property (
        wma |=> output_enable_a_o == $past(wdata_i[0]))
        else $error("pin enable a wrong");
    chk_pin_enable_b: assert property (
        wmb |=> output_enable_b_o == $past(wdata_i[0]))
        else $error("pin enable b wrong");
    chk_action_bits_zero: assert property (
        rdm |=> rdata_o[5] == 0 && rdata_o[3:2] == 2'b00)
        else $error("action bits read nonzero");
    chk_flop_set_a: assert property (
        wma && wdata_i[6:1] == 6'b000100 |-> ##[1:2] wave_output_a_o)
        else $error("flop set failed");
    chk_flop_clear_a: assert property (
        wma && wdata_i[6:1] == 6'b000010 |-> ##[1:2] !wave_output_a_o)
        else $error("flop clear failed");
    // Stop lands one cycle late, so one pending pulse is tolerated
    chk_stop_quiet_a: assert property (
        wma && !wdata_i[7] |-> ##2 !match_irq_a_o [*4])
        else $error("irq after stop");
    chk_pwm_stop_idle: assert property (
        wma && wdata_i[7:6] == 2'b01 |-> ##3 wave_output_a_o == $past(wdata_i[1], 3))
        else $error("pwm stop level wrong");
    chk_irq_a_pulse: assert property (match_irq_a_o |=> !match_irq_a_o)
        else $error("irq a too long");
    chk_irq_b_pulse: assert property (match_irq_b_o |=> !match_irq_b_o)
        else $error("irq b too long");
    chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |->
        !match_irq_a_o && !wave_output_a_o && !output_enable_a_o && rdata_o == 8'h00)
        else $error("outputs live in reset");
    cover property (match_irq_a_o && match_irq_b_o);
    cover property (wave_output_a_o && output_enable_a_o);
    cover property (match_irq_b_o);
endmodule
bind tmr_dual_timer tmr_dual_timer_monitor u_mon (.clk_i, .sys_rst_i, .addr_i, .wr_i, .rd_i,
    .wdata_i, .rdata_o, .event_input_a_i, .event_input_b_i, .wave_output_a_o, .wave_output_b_o,
    .output_enable_a_o, .output_enable_b_o, .match_irq_a_o, .match_irq_b_o);

/* dv/tmr_pin_model.sv */
`timescale 1ns/1ns
module tmr_pin_model (
    input wire logic clk_i,
    input wire logic [1:0] go_i,
    input wire logic [3:0] count_i,
    output logic event_a_o = 1'b0,
    output logic event_b_o = 1'b0,
    output logic busy_o = 1'b0
);
    logic [1:0] sel;
    // Each level held four cycles, well past the read pause and synchroniser
    initial forever begin
        @(posedge clk_i);
        if (go_i != 2'b00) begin
            sel = go_i;
            busy_o <= 1'b1;
            repeat (count_i) begin
                repeat (4) @(negedge clk_i);
                if (sel[0]) event_a_o = 1'b1;
                if (sel[1]) event_b_o = 1'b1;
                repeat (4) @(negedge clk_i);
                event_a_o = 1'b0;
                event_b_o = 1'b0;
            end
            @(negedge clk_i);
            busy_o <= 1'b0;
        end
    end
endmodule

/* dv/tmr_dual_timer_bench.sv */
`timescale 1ns/1ns
`include "tmr_map.vh"
module tmr_dual_timer_bench;
    logic clk_i = 0, sys_rst_i = 0, wr_i = 0, rd_i = 0, rd_d = 0, busy;
    logic [`TMR_ADDR_W-1:0] addr_i = '0;
    logic [7:0] wdata_i = 8'h00, rdata_o, v;
    logic event_input_a_i, event_input_b_i, wave_output_a_o, wave_output_b_o;
    logic output_enable_a_o, output_enable_b_o, match_irq_a_o, match_irq_b_o;
    logic [1:0] go = 2'b00;
    logic [3:0] npulse = 4'h0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h0bd30aa6;
    int error_cnt = 0, num_checks = 0, n, irqb = 0, irq0 = 0;
    int ratio[8] = '{0, 0, 4, 8, 16, 32, 128, 512};
    logic [7:0] cv[2] = '{8'h00, 8'hff};
    logic [19:0] regs[8] = '{`TMR_MODE_A_ADDR, `TMR_MODE_B_ADDR, `TMR_CLKSEL_A_ADDR,
        `TMR_CLKSEL_B_ADDR, `TMR_COMPARE_A_ADDR, `TMR_COMPARE_B_ADDR, `TMR_COUNTER_A_ADDR,
        `TMR_COUNTER_B_ADDR};

    initial forever #50 clk_i = ~clk_i;

    tmr_dual_timer u_dut (.clk_i, .sys_rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
        .event_input_a_i, .event_input_b_i, .wave_output_a_o, .wave_output_b_o,
        .output_enable_a_o, .output_enable_b_o, .match_irq_a_o, .match_irq_b_o);
    tmr_pin_model u_pins (.clk_i, .go_i(go), .count_i(npulse), .event_a_o(event_input_a_i),
        .event_b_o(event_input_b_i), .busy_o(busy));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One-cycle strobes with an idle cycle between, per the bus contract
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_i = 1;
        addr_i = a;
        wdata_i = d;
        @(negedge clk_i);
        wr_i = 0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(negedge clk_i);
        rd_i = 1;
        addr_i = a;
        exp_q.push_back(e);
        @(negedge clk_i);
        rd_i = 0;
    endtask

    // Read data lands the cycle after the strobe; oldest note is matched
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d)
            check(rdata_o, exp_q.pop_front());
        if (match_irq_b_o === 1'b1)
            irqb++;
    end

    task automatic wait_irq(input logic b, output int k);
        k = 0;
        while ((b ? match_irq_b_o : match_irq_a_o) !== 1'b1) begin
            @(negedge clk_i);
            k++;
            if (k > 3000) begin
                error_cnt++;
                report_and_stop();
            end
        end
    endtask

    // Spacing of two successive interrupt pulses in clocks
    task automatic period(input logic b, input int exp);
        wait_irq(b, n);
        @(negedge clk_i);
        wait_irq(b, n);
        check(n + 1, exp);
    endtask

    task automatic pulses(input logic [3:0] k);
        int w;
        @(negedge clk_i);
        go = 2'b10;
        npulse = k;
        @(negedge clk_i);
        go = 2'b00;
        for (w = 0; busy !== 1'b0; w++) begin
            @(negedge clk_i);
            if (w > 200) begin
                error_cnt++;
                report_and_stop();
            end
        end
        // Last pin edge still needs about five clocks through the synchroniser
        repeat (6) @(negedge clk_i);
    endtask

    initial begin
        #10 sys_rst_i = 1;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(20'hff00, 8'h00);
        wr(`TMR_MODE_A_ADDR, 8'h7b);
        rd(`TMR_MODE_A_ADDR, 8'h43);
        wr(`TMR_MODE_B_ADDR, 8'h7b);
        rd(`TMR_MODE_B_ADDR, 8'h53);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = seed[7:0];
            wr(`TMR_COMPARE_B_ADDR, v);
            rd(`TMR_COMPARE_B_ADDR, v);
            wr(`TMR_CLKSEL_B_ADDR, {5'h00, v[2:0]});
            rd(`TMR_CLKSEL_B_ADDR, {5'h00, v[2:0]});
        end
        wr(`TMR_COUNTER_A_ADDR, 8'h55);
        rd(`TMR_COUNTER_A_ADDR, 8'h00);
        wr(`TMR_MODE_A_ADDR, 8'h00);
        wr(`TMR_MODE_B_ADDR, 8'h00);
        wr(`TMR_COMPARE_A_ADDR, 8'h01);
        for (int c = 2; c < 8; c++) begin
            wr(`TMR_CLKSEL_A_ADDR, c[7:0]);
            wr(`TMR_MODE_A_ADDR, 8'h80);
            period(0, 2 * ratio[c]);
            wr(`TMR_MODE_A_ADDR, 8'h00);
            rd(`TMR_COUNTER_A_ADDR, 8'h00);
        end
        wr(`TMR_CLKSEL_A_ADDR, 8'h02);
        foreach (cv[i]) begin
            wr(`TMR_COMPARE_A_ADDR, cv[i]);
            wr(`TMR_MODE_A_ADDR, 8'h80);
            period(0, 4 * (cv[i] + 1));
            if (cv[i] == 8'h00) begin
                // Rewrite lands on the next match: no clear, so the count moves on
                repeat (2) @(negedge clk_i);
                wr(`TMR_COMPARE_A_ADDR, 8'h00);
                rd(`TMR_COUNTER_A_ADDR, 8'h01);
            end
            wr(`TMR_MODE_A_ADDR, 8'h00);
        end
        // Square wave: flop cleared, preset high, then inverted on each match
        wr(`TMR_COMPARE_A_ADDR, 8'h03);
        wr(`TMR_MODE_A_ADDR, 8'h04);
        wr(`TMR_MODE_A_ADDR, 8'h09);
        @(negedge clk_i);
        check({output_enable_a_o, wave_output_a_o}, 2'b11);
        wr(`TMR_MODE_A_ADDR, 8'h8b);
        for (int i = 0; i < 2; i++) begin
            wait_irq(0, n);
            repeat (2) @(negedge clk_i);
            check(wave_output_a_o, i[0]);
        end
        wr(`TMR_MODE_A_ADDR, 8'h04);
        @(negedge clk_i);
        check(wave_output_a_o, 1'b0);
        // External events on the second channel, both edges, with toggle on match
        wr(`TMR_CLKSEL_B_ADDR, 8'h01);
        wr(`TMR_COMPARE_B_ADDR, 8'h02);
        wr(`TMR_MODE_B_ADDR, 8'h8a);
        pulses(2);
        rd(`TMR_COUNTER_B_ADDR, 8'h02);
        check(wave_output_b_o, 1'b1);
        irq0 = irqb;
        pulses(1);
        check(irqb - irq0, 1);
        check(wave_output_b_o, 1'b0);
        check(wave_output_a_o, 1'b0);
        rd(`TMR_COUNTER_B_ADDR, 8'h00);
        wr(`TMR_MODE_B_ADDR, 8'h00);
        wr(`TMR_CLKSEL_B_ADDR, 8'h00);
        wr(`TMR_MODE_B_ADDR, 8'h80);
        pulses(2);
        rd(`TMR_COUNTER_B_ADDR, 8'h02);
        wr(`TMR_MODE_B_ADDR, 8'h00);
        // Cascade: joint match at 0x0201, then stop through the first channel
        wr(`TMR_COMPARE_A_ADDR, 8'h01);
        wr(`TMR_COMPARE_B_ADDR, 8'h02);
        wr(`TMR_MODE_B_ADDR, 8'h90);
        wr(`TMR_MODE_A_ADDR, 8'h80);
        period(0, 2056);
        repeat (1100) @(negedge clk_i);
        rd(`TMR_COUNTER_B_ADDR, 8'h01);
        wr(`TMR_MODE_A_ADDR, 8'h00);
        rd(`TMR_COUNTER_B_ADDR, 8'h00);
        wr(`TMR_MODE_B_ADDR, 8'h00);
        // PWM: interrupt on overflow, active-low idle level after stop
        wr(`TMR_COMPARE_A_ADDR, 8'h40);
        wr(`TMR_MODE_A_ADDR, 8'hc1);
        period(0, 1024);
        wr(`TMR_MODE_A_ADDR, 8'h42);
        repeat (3) @(negedge clk_i);
        check(wave_output_a_o, 1'b1);
        @(negedge clk_i);
        sys_rst_i = 1;
        @(negedge clk_i);
        sys_rst_i = 0;
        rd(`TMR_MODE_A_ADDR, 8'h00);
        repeat (2) @(negedge clk_i);
        report_and_stop();
    end
endmodule
